// *** rtl/eeprom_front_pkg.sv ***
// Shared constants for the serial EEPROM bus front end
package eeprom_front_pkg;
    localparam int        LOC_ADDR_W    = 17;
    localparam int        PIN_SYNC_W    = 5;
    localparam logic [3:0] TYPE_ARRAY   = 4'ha;
    localparam logic [3:0] TYPE_ID_PAGE = 4'hb;
    localparam int        SEL_TYPE_HI   = 7;
    localparam int        SEL_TYPE_LO   = 4;
    localparam int        SEL_STRAP_HI  = 3;
    localparam int        SEL_STRAP_LO  = 2;
    localparam int        SEL_TOP_BIT   = 1;
    localparam int        SEL_DIR_BIT   = 0;
    localparam logic [2:0] LAST_BIT_CNT = 3'h7;
    localparam logic [7:0] BYTE_RESET   = 8'h00;
    localparam logic [16:0] ADDR_RESET  = 17'h00000;
    localparam logic [4:0] SYNC_RESET   = 5'h03;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_END,
        ST_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_TX_LOAD
    } front_state_t;

    typedef enum logic [1:0] {
        PH_SELECT,
        PH_ADDR_HI,
        PH_ADDR_LO,
        PH_DATA
    } byte_phase_t;
endpackage

// *** rtl/line_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module line_sync #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            stage1_reg <= RESET_VAL;
            sync_out   <= RESET_VAL;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule

// *** rtl/bus_condition.sv ***
// Clock edge and Start/Stop detection on synchronised bus lines
`timescale 1ns/100ps
module bus_condition (
    input  wire logic clock_in,
    input  wire logic rstn_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_rise_out,
    output logic      scl_fall_out,
    output logic      start_out,
    output logic      stop_out
);
    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_in;
            sda_prev_reg <= sda_in;
        end
    end

    assign scl_rise_out = !scl_prev_reg && scl_in;
    assign scl_fall_out = scl_prev_reg && !scl_in;
    // Data edges only count as conditions while clock stays high
    assign start_out    = scl_prev_reg && scl_in && sda_prev_reg && !sda_in;  // see RULE_04
    assign stop_out     = scl_prev_reg && scl_in && !sda_prev_reg && sda_in;  // see RULE_07
endmodule

// *** rtl/eeprom_bus_front.sv ***
// Serial EEPROM two-wire slave front end: select decode, addressing, ack and read shifting
//
// Function
// RULE_01: 17-bit location address, byte-wide array.
// RULE_02: Select identification page via separate type code.
// RULE_03: Slave only; master drives the clock.
// RULE_04: Start is data falling while clock high.
// RULE_05: Master sends Start before any instruction.
// RULE_06: Watch for Start except during write cycle.
// RULE_07: Stop is data rising while clock high.
// RULE_08: Unacknowledged read byte then Stop gives standby.
// RULE_09: Stop closing a write launches write cycle.
// RULE_10: Capture data on each clock rising edge.
// RULE_11: Master changes data only while clock low.
// RULE_12: Transmitter releases line; receiver acks ninth clock.
// RULE_13: Data output only pulls low or releases.
// RULE_14: Select code sent right after Start, MSB first.
// RULE_15: Type 1010 array, 1011 page; straps match.
// RULE_16: Last select bit: one read, zero write.
// RULE_17: Matching select code acknowledged on ninth clock.
// RULE_18: Mismatch: stay off bus until next Start.
// RULE_19: Unconnected chip-enable straps read as low.
// RULE_20: Write protect high blocks all writes.
// RULE_21: Write protect high: data bytes not acknowledged.
// RULE_22: Reset clears state, bus ignored meanwhile.
// RULE_23: Stop enters standby unless write cycle runs.
// RULE_24: Two acknowledged address bytes, high then low.
// RULE_25: Top address bit from select code bit one.
// RULE_26: Write cycle only after data ack slot.
// RULE_27: Busy write cycle: line off, requests ignored.
// RULE_28: Line released outside ack and read bits.
`timescale 1ns/100ps
module eeprom_bus_front #(
    parameter int ADDR_W = eeprom_front_pkg::LOC_ADDR_W
) (
    input  wire logic              clock_in,
    input  wire logic              rstn_in,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_out,
    input  wire logic              strap_select_low_in,
    input  wire logic              strap_select_high_in,
    input  wire logic              write_protect_input_in,
    input  wire logic              id_page_locked_in,
    input  wire logic              write_busy_in,
    input  wire logic [7:0]        rd_data_in,
    output logic [ADDR_W-1:0]      mem_addr_out,
    output logic                   id_page_sel_out,
    output logic [7:0]             wr_data_out,
    output logic                   wr_strobe_out,
    output logic                   rd_strobe_out,
    output logic                   write_start_out,
    output logic                   standby_out
);
    import eeprom_front_pkg::*;

    if (ADDR_W < LOC_ADDR_W || ADDR_W > 24) begin
        $error("ADDR_W must lie between 17 and 24");
    end

    logic [PIN_SYNC_W-1:0] pins_sync;
    logic                  scl_s;
    logic                  sda_s;
    logic                  wp_s;
    logic [1:0]            strap_s;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_cond;
    logic                  stop_cond;

    front_state_t          state_reg;
    byte_phase_t           phase_reg;
    logic [2:0]            bit_cnt_reg;
    logic [7:0]            shift_reg;
    logic [7:0]            tx_reg;
    logic                  ack_reg;
    logic                  read_dir_reg;
    logic                  wr_armed_reg;
    logic                  wr_any_reg;
    logic [7:0]            byte_next;
    logic                  byte_done;
    logic                  sel_match;

    line_sync #(
        .WIDTH     (PIN_SYNC_W),
        .RESET_VAL (SYNC_RESET)
    ) u_pins (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .async_in ({strap_select_high_in, strap_select_low_in, write_protect_input_in, sda_in, scl_in}),
        .sync_out (pins_sync)
    );

    assign scl_s   = pins_sync[0];
    assign sda_s   = pins_sync[1];
    assign wp_s    = pins_sync[2];
    assign strap_s = pins_sync[4:3];

    bus_condition u_cond (
        .clock_in     (clock_in),
        .rstn_in      (rstn_in),
        .scl_in       (scl_s),
        .sda_in       (sda_s),
        .scl_rise_out (scl_rise),
        .scl_fall_out (scl_fall),
        .start_out    (start_cond),
        .stop_out     (stop_cond)
    );

    // Select code layout: type nibble, two straps, top address bit, direction
    function automatic logic select_ok(input logic [7:0] code, input logic [1:0] straps);
        logic type_ok;
        type_ok   = (code[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_ARRAY)
                 || (code[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_ID_PAGE);                         // see RULE_15
        select_ok = type_ok && (code[SEL_STRAP_HI:SEL_STRAP_LO] == straps);                 // see RULE_19
    endfunction

    assign byte_next = {shift_reg[6:0], sda_s};                                              // see RULE_14
    assign byte_done = (state_reg == ST_RX) && scl_rise && (bit_cnt_reg == LAST_BIT_CNT);
    assign sel_match = select_ok(byte_next, strap_s);

    // Protocol sequencing; a busy write cycle keeps the front end deaf to Start
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            state_reg   <= ST_IDLE;                                                          // see RULE_22
            phase_reg   <= PH_SELECT;
            bit_cnt_reg <= 3'h0;
        end else if (stop_cond) begin
            state_reg   <= ST_IDLE;                                                          // see RULE_07, RULE_23
            phase_reg   <= PH_SELECT;
        end else if (start_cond && !write_busy_in) begin
            state_reg   <= ST_RX;                                                            // see RULE_06, RULE_27
            phase_reg   <= PH_SELECT;
            bit_cnt_reg <= 3'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    bit_cnt_reg <= 3'h0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == LAST_BIT_CNT) begin
                            // A stranger's code sends us back to standby without answer
                            state_reg <= (phase_reg == PH_SELECT && !sel_match) ? ST_IDLE : ST_RX_END;  // see RULE_18
                        end
                    end
                end
                ST_RX_END: begin
                    if (scl_fall) begin
                        state_reg <= ST_ACK;                                                 // see RULE_12
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 3'h0;
                        unique case (phase_reg)
                            PH_SELECT: begin
                                state_reg <= read_dir_reg ? ST_TX : ST_RX;                   // see RULE_16
                                phase_reg <= read_dir_reg ? PH_SELECT : PH_ADDR_HI;          // see RULE_24
                            end
                            PH_ADDR_HI: begin
                                state_reg <= ST_RX;
                                phase_reg <= PH_ADDR_LO;
                            end
                            PH_ADDR_LO, PH_DATA: begin
                                state_reg <= ST_RX;
                                phase_reg <= PH_DATA;
                            end
                        endcase
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                    if (scl_fall && bit_cnt_reg == 3'h0) begin
                        state_reg <= ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        state_reg <= sda_s ? ST_IDLE : ST_TX_LOAD;                           // see RULE_08
                    end
                end
                ST_TX_LOAD: begin
                    if (scl_fall) begin
                        state_reg   <= ST_TX;
                        bit_cnt_reg <= 3'h0;
                    end
                end
            endcase
        end
    end

    // Receive shifter and ack decision, taken at the eighth rising edge
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            shift_reg    <= BYTE_RESET;
            ack_reg      <= 1'b0;
            read_dir_reg <= 1'b0;
        end else begin
            if (state_reg == ST_RX && scl_rise) begin
                shift_reg <= byte_next;                                                      // see RULE_10
            end
            if (byte_done) begin
                if (phase_reg == PH_SELECT) begin
                    ack_reg      <= sel_match;                                               // see RULE_17
                    read_dir_reg <= byte_next[SEL_DIR_BIT];                                  // see RULE_16
                end else if (phase_reg == PH_DATA) begin
                    ack_reg <= !wp_s && !(id_page_sel_out && id_page_locked_in);             // see RULE_21
                end else begin
                    ack_reg <= 1'b1;                                                         // see RULE_24
                end
            end
        end
    end

    // Address pointer: write data rolls over within the page, reads run on
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            mem_addr_out    <= ADDR_W'(ADDR_RESET);
            id_page_sel_out <= 1'b0;
        end else if (byte_done) begin
            unique case (phase_reg)
                PH_SELECT: begin
                    if (sel_match) begin
                        id_page_sel_out <= (byte_next[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_ID_PAGE);  // see RULE_02
                        if (byte_next[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_ARRAY) begin
                            mem_addr_out[16] <= byte_next[SEL_TOP_BIT];                      // see RULE_25, RULE_01
                        end
                    end
                end
                PH_ADDR_HI: mem_addr_out[15:8] <= byte_next;                                 // see RULE_24
                PH_ADDR_LO: mem_addr_out[7:0]  <= byte_next;
                PH_DATA: begin
                    if (!wp_s && !(id_page_sel_out && id_page_locked_in)) begin
                        mem_addr_out[7:0] <= mem_addr_out[7:0] + 8'h01;
                    end
                end
            endcase
        end else if (state_reg == ST_TX_ACK && scl_rise && !sda_s) begin
            mem_addr_out <= mem_addr_out + ADDR_W'(1);
        end
    end

    // Byte handed to the page buffer only when writes are allowed
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            wr_data_out   <= BYTE_RESET;
            wr_strobe_out <= 1'b0;
            rd_strobe_out <= 1'b0;
        end else begin
            wr_strobe_out <= byte_done && phase_reg == PH_DATA && !wp_s
                          && !(id_page_sel_out && id_page_locked_in);                        // see RULE_20
            rd_strobe_out <= state_reg == ST_TX_ACK && scl_rise && !sda_s;
            if (byte_done && phase_reg == PH_DATA) begin
                wr_data_out <= byte_next;
            end
        end
    end

    // Write launch: armed only across the slot following a data ack
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            wr_armed_reg    <= 1'b0;
            wr_any_reg      <= 1'b0;
            write_start_out <= 1'b0;
        end else begin
            write_start_out <= stop_cond && wr_armed_reg && wr_any_reg;                      // see RULE_09, RULE_26
            if (stop_cond || (start_cond && !write_busy_in)) begin
                wr_armed_reg <= 1'b0;
                wr_any_reg   <= 1'b0;
            end else begin
                if (state_reg == ST_ACK && scl_fall && phase_reg == PH_DATA) begin
                    wr_armed_reg <= 1'b1;                                                    // see RULE_26
                end else if (scl_fall) begin
                    // Stop sits in the high half of the tenth clock, so only the next fall closes the slot
                    wr_armed_reg <= 1'b0;
                end
                if (wr_strobe_out) begin
                    wr_any_reg <= 1'b1;
                end
            end
        end
    end

    // Open-drain driver: level is always low, only the enable moves
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            sda_out    <= 1'b0;
            sda_oe_out <= 1'b0;
            tx_reg     <= BYTE_RESET;
        end else begin
            sda_out <= 1'b0;                                                                 // see RULE_13
            if (stop_cond || (start_cond && !write_busy_in) || write_busy_in) begin
                sda_oe_out <= 1'b0;                                                          // see RULE_27
            end else if (state_reg == ST_RX_END && scl_fall) begin
                sda_oe_out <= ack_reg;                                                       // see RULE_12, RULE_17
            end else if (state_reg == ST_ACK && scl_fall) begin
                if (phase_reg == PH_SELECT && read_dir_reg) begin
                    tx_reg     <= rd_data_in;
                    sda_oe_out <= !rd_data_in[7];
                end else begin
                    sda_oe_out <= 1'b0;                                                      // see RULE_28
                end
            end else if (state_reg == ST_TX && scl_fall) begin
                // Slave never drives the clock, it only follows falling edges
                tx_reg     <= {tx_reg[6:0], 1'b0};                                           // see RULE_03
                sda_oe_out <= (bit_cnt_reg == 3'h0) ? 1'b0 : !tx_reg[6];                    // see RULE_12
            end else if (state_reg == ST_TX_LOAD && scl_fall) begin
                tx_reg     <= rd_data_in;
                sda_oe_out <= !rd_data_in[7];
            end else if (state_reg == ST_IDLE) begin
                sda_oe_out <= 1'b0;                                                          // see RULE_18
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            standby_out <= 1'b1;
        end else begin
            standby_out <= (state_reg == ST_IDLE) && !write_busy_in;                         // see RULE_23
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    start_accept_a: assert property (start_cond && !stop_cond && !write_busy_in |=> state_reg == ST_RX && bit_cnt_reg == 3'h0)  // see RULE_06
        else $error("Start not taken");
    busy_ignore_a: assert property (write_busy_in && state_reg == ST_IDLE && !$past(start_cond) |=> state_reg == ST_IDLE && !sda_oe_out)  // see RULE_27
        else $error("Busy front end answered");
    stop_standby_a: assert property (stop_cond |=> state_reg == ST_IDLE ##1 !sda_oe_out)   // see RULE_07
        else $error("Stop did not end transfer");
    write_launch_a: assert property (stop_cond && wr_armed_reg && wr_any_reg |=> write_start_out)  // see RULE_09
        else $error("Write cycle not launched");
    launch_cause_a: assert property (write_start_out |-> $past(stop_cond) && $past(wr_armed_reg))  // see RULE_26
        else $error("Write launched outside data ack slot");
    select_ack_a: assert property (state_reg == ST_RX_END && phase_reg == PH_SELECT && scl_fall && !stop_cond
                                   && !start_cond && !write_busy_in |=> sda_oe_out)        // see RULE_17
        else $error("Matching select not acknowledged");
    protect_nack_a: assert property (byte_done && phase_reg == PH_DATA && wp_s |=> !ack_reg && !wr_strobe_out)  // see RULE_21
        else $error("Protected data byte accepted");
    release_idle_a: assert property (sda_oe_out |-> $past(state_reg) inside {ST_RX_END, ST_ACK, ST_TX, ST_TX_LOAD})  // see RULE_28
        else $error("Line driven outside ack or read bits");
    sample_rise_a: assert property (state_reg == ST_RX && scl_rise && !start_cond && !stop_cond |=> shift_reg[0] == $past(sda_s))  // see RULE_10
        else $error("Data not captured on rising edge");
    mismatch_off_a: assert property (byte_done && phase_reg == PH_SELECT && !sel_match && !stop_cond && !start_cond
                                     |=> state_reg == ST_IDLE ##1 !sda_oe_out)     // see RULE_18
        else $error("Mismatched select answered");

    read_byte_c: cover property (state_reg == ST_TX_ACK && scl_rise && !sda_s);
    write_done_c: cover property (write_start_out);
    protect_c: cover property (byte_done && phase_reg == PH_DATA && wp_s);
endmodule

// *** sim/bus_master_model.sv ***
// Two-wire bus master model: drives the bus clock and pulls the data line
`timescale 1ns/100ps
module bus_master_model (
    output logic      scl_out,
    output logic      sda_oe_out,
    input  wire logic sda_in
);
    // Clock idles high between frames, data line released
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic put_bit(input logic b);
        sda_oe_out = !b;
        #31 scl_out = 1'b1;
        #62 scl_out = 1'b0;
        #32;
    endtask
    task automatic get_bit(output logic b);
        sda_oe_out = 1'b0;
        #31 scl_out = 1'b1;
        #31 b = sda_in;
        #31 scl_out = 1'b0;
        #32;
    endtask
    task automatic start();
        sda_oe_out = 1'b0;
        #31 scl_out = 1'b1;
        #31 sda_oe_out = 1'b1;
        #31 scl_out = 1'b0;
        #32;
    endtask
    task automatic stop();
        sda_oe_out = 1'b1;
        #31 scl_out = 1'b1;
        #31 sda_oe_out = 1'b0;
        #31;
    endtask
    task automatic send(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(b);
        ack = !b;
    endtask
    task automatic recv(input logic ack, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) get_bit(v[i]);
        put_bit(!ack);
    endtask
endmodule

// *** sim/serial_eeprom_bus_slave_front_end_test.sv ***
// Self-checking bench for the serial EEPROM bus front end
`timescale 1ns/100ps
module serial_eeprom_bus_slave_front_end_test;
    import eeprom_front_pkg::*;
    typedef struct packed {logic [7:0] sel; logic [1:0] straps; logic ack;} row_t;
    logic        clock_in, rstn_in, scl, mst_oe, s_lo, s_hi, wp, id_lock, busy, ack;
    logic        sda_out, sda_oe, id_sel, wr_stb, rd_stb, w_start, standby;
    logic [7:0]  rd_data, wr_data, got;
    logic [16:0] addr;
    wire         sda_line = !(mst_oe || (sda_oe && !sda_out));
    int          miscompares = 0, checks_done = 0, n_wr = 0, n_ws = 0, n_rd = 0;
    row_t        rows[8] = '{'{8'ha0, 2'b00, 1'b1}, '{8'ha1, 2'b00, 1'b1}, '{8'hac, 2'b11, 1'b1},
                             '{8'ha8, 2'b10, 1'b1}, '{8'ha4, 2'b10, 1'b0}, '{8'hb2, 2'b00, 1'b1},
                             '{8'h90, 2'b00, 1'b0}, '{8'he0, 2'b00, 1'b0}};

    eeprom_bus_front uut (.clock_in(clock_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .strap_select_low_in(s_lo), .strap_select_high_in(s_hi),
        .write_protect_input_in(wp), .id_page_locked_in(id_lock), .write_busy_in(busy), .rd_data_in(rd_data),
        .mem_addr_out(addr), .id_page_sel_out(id_sel), .wr_data_out(wr_data), .wr_strobe_out(wr_stb),
        .rd_strobe_out(rd_stb), .write_start_out(w_start), .standby_out(standby));
    bus_master_model mst (.scl_out(scl), .sda_oe_out(mst_oe), .sda_in(sda_line));

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Outputs are looked at mid-cycle, clear of the edge that moves them
    always @(negedge clock_in) begin
        if (wr_stb) n_wr++;
        if (w_start) n_ws++;
        if (rd_stb) n_rd++;
        if (sda_oe) check(17'(sda_out), 17'h0);
    end
    initial begin
        repeat (80000) @(posedge clock_in);
        miscompares++;
        wrap_up();
    end
    // Select, two address bytes, one data byte, then Stop in the slot after the data ack
    task automatic wr_frame(input logic [7:0] sel, input logic [7:0] data, input logic exp);
        mst.start();
        mst.send(sel, ack);
        check(17'(ack), 17'h1);
        mst.send(8'h12, ack);
        check(17'(ack), 17'h1);
        mst.send(8'h34, ack);
        check(17'(ack), 17'h1);
        mst.send(data, ack);
        check(17'(ack), 17'(exp));
        mst.stop();
        repeat (8) @(negedge clock_in);
    endtask
    initial begin
        {rstn_in, s_lo, s_hi, wp, id_lock, busy} = 6'h00;
        rd_data = 8'h3c;
        repeat (16) @(negedge clock_in);
        check(17'(standby), 17'h1);
        check(17'(sda_oe), 17'h0);
        check(addr, 17'h0);
        rstn_in = 1'b1;
        repeat (8) @(negedge clock_in);
        foreach (rows[i]) begin
            {s_hi, s_lo} = rows[i].straps;
            mst.start();
            mst.send(rows[i].sel, ack);
            check(17'(ack), 17'(rows[i].ack));
            if (ack && rows[i].sel[0]) begin
                mst.recv(1'b0, got);
                check(17'(got), 17'h3c);
            end
            mst.stop();
            repeat (8) @(negedge clock_in);
            check(17'(standby), 17'h1);
        end
        check(17'(n_ws), 17'h0);
        {s_hi, s_lo} = 2'b01;
        wr_frame(8'ha6, 8'h5a, 1'b1);
        check(17'(wr_data), 17'h5a);
        check(17'(n_wr), 17'h1);
        check(17'(n_ws), 17'h1);
        check(addr, 17'h11235);
        wp = 1'b1;
        wr_frame(8'ha6, 8'h77, 1'b0);
        check(17'(n_wr), 17'h1);
        check(17'(n_ws), 17'h1);
        check(addr, 17'h11234);
        wp = 1'b0;
        id_lock = 1'b1;
        wr_frame(8'hb4, 8'h11, 1'b0);
        check(17'(id_sel), 17'h1);
        check(17'(n_wr), 17'h1);
        id_lock = 1'b0;
        mst.start();
        mst.send(8'ha6, ack);
        mst.send(8'h12, ack);
        mst.send(8'h34, ack);
        mst.start();
        mst.send(8'ha7, ack);
        check(17'(ack), 17'h1);
        check(addr, 17'h11234);
        mst.recv(1'b1, got);
        check(17'(got), 17'h3c);
        check(17'(n_rd), 17'h1);
        check(addr, 17'h11235);
        mst.recv(1'b0, got);
        mst.stop();
        repeat (8) @(negedge clock_in);
        check(17'(standby), 17'h1);
        busy = 1'b1;
        mst.start();
        mst.send(8'ha6, ack);
        check(17'(ack), 17'h0);
        mst.stop();
        @(negedge clock_in);
        busy = 1'b0;
        // Bus traffic during a mid-run reset must go unanswered
        rstn_in = 1'b0;
        mst.start();
        mst.send(8'ha6, ack);
        check(17'(ack), 17'h0);
        check(17'(standby), 17'h1);
        mst.stop();
        @(negedge clock_in);
        rstn_in = 1'b1;
        repeat (8) @(negedge clock_in);
        mst.start();
        mst.send(8'ha6, ack);
        check(17'(ack), 17'h1);
        check(addr, 17'h10000);
        mst.stop();
        repeat (8) @(negedge clock_in);
        wrap_up();
    end
endmodule
